/* File: rtl/ssb_spi_status.sv */
// SPI status flags, clearing sequences and baud selection
//
// Behaviour
// - Divisor is (preselect+1) times two to the power (select+1).
// - Serial bit rate is bus clock divided by the divisor.
// - Both fields at maximum divide the bus clock by 2048.
// - Width 0 moves 8-bit words in low byte; 1 moves 16-bit words.
// - Status readable any time; writes to it change nothing.
// - Receive full flag (bit 7) sets when received data reaches data register.
// - Transmit empty flag (bit 5) is 1 while transmit register empty.
// - Mode fault flag (bit 4) sets on select low as master with detect on.
// - Status read with mode fault set, then control one write, clears it.
// - 8-bit: armed status read then low byte read clears receive full.
// - 16-bit: low byte read alone still clears; high byte data lost.
// - High byte reads never touch receive full flag.
// - 16-bit: one word read after armed status read clears receive full.
// - 8-bit: armed status read then low byte write loads and clears empty.
// - Data byte writes while transmit empty is 0 are ignored.
// - 16-bit: armed low byte write alone clears empty; high byte undefined.
// - High byte writes never touch transmit empty flag.
// - 16-bit: high then low, or word write, loads the full word.
// - Interrupt enable with mode fault set requests an interrupt.
`timescale 1ns/1ps
module ssb_spi_status #(
	parameter int ADR_W = 10 // Byte address width
) (
	input  wire logic             core_clk,   // Bus clock, 25 MHz
	input  wire logic             rst_n,      // Async reset, active low
	input  wire logic             wb_cyc_i,   // Wishbone cycle
	input  wire logic             wb_stb_i,   // Wishbone strobe
	input  wire logic             wb_we_i,    // Wishbone write
	input  wire logic [ADR_W-1:0] wb_adr_i,   // Byte address
	input  wire logic [3:0]       wb_sel_i,   // Byte enables
	input  wire logic [31:0]      wb_dat_i,   // Write data
	output logic      [31:0]      wb_dat_o,   // Read data
	output logic                  wb_ack_o,   // Acknowledge
	output logic                  spi_sck_o,  // Serial clock out
	output logic                  spi_mosi_o, // Serial data out
	input  wire logic             spi_miso_i, // Serial data in
	input  wire logic             spi_ss_n_i, // Slave select in
	output logic                  spi_irq_o   // Interrupt request
);
	logic        ack_q;
	logic [31:0] dat_q;
	logic [7:0]  ctrl1_q;
	logic [7:0]  ctrl2_q;
	logic [7:0]  baud_q;
	logic        rxf_q;
	logic        txe_q;
	logic        mode_fault_flag_q;
	logic        rx_arm_q;
	logic        tx_arm_q;
	logic        mode_fault_flag_arm_q;
	logic [15:0] rx_q;
	logic [15:0] tx_q;
	logic [15:0] pend_q;
	logic        pend_vld_q;
	logic [15:0] sh_q;
	logic        rxbit_q;
	logic        phase_q;
	logic        sck_q;
	logic [4:0]  cnt_q;
	ssb_pkg::ssb_state_t state_q;

	// Bus decode
	wire       req     = wb_cyc_i && wb_stb_i && !ack_q;
	wire       rd      = req && !wb_we_i;
	wire       wr      = req && wb_we_i && wb_sel_i[0];
	wire [7:0] idx     = wb_adr_i[9:2];
	wire       in_map  = ((wb_adr_i >> 10) == '0);
	wire       hit_bd  = in_map && (idx == ssb_pkg::IDX_BAUD);
	wire       hit_st  = in_map && (idx == ssb_pkg::IDX_STATUS);
	wire       hit_hi  = in_map && (idx == ssb_pkg::IDX_DHIGH);
	wire       hit_lo  = in_map && (idx == ssb_pkg::IDX_DLOW);
	wire       hit_c1  = in_map && (idx == ssb_pkg::IDX_CTRL1);
	wire       hit_c2  = in_map && (idx == ssb_pkg::IDX_CTRL2);
	wire       hit_wd  = in_map && (idx == ssb_pkg::IDX_DWORD);

	wire       en      = ctrl1_q[ssb_pkg::C1_EN_BIT];
	wire       mstr    = ctrl1_q[ssb_pkg::C1_MSTR_BIT];
	wire       ie      = ctrl1_q[ssb_pkg::C1_IE_BIT];
	wire       wide    = ctrl2_q[ssb_pkg::C2_WIDTH_BIT];
	wire       mode_fault_detect_enable  = ctrl2_q[ssb_pkg::C2_MODE_FAULT_DETECT_ENABLE_BIT];

	// Unused status bits tied to zero
	wire [7:0] status  = {rxf_q, 1'b0, txe_q, mode_fault_flag_q, 4'h0};

	// Register read mux; unmapped addresses read zero
	wire [31:0] rdata =
		hit_bd ? {24'h0, baud_q} :
		hit_st ? {24'h0, status} :
		hit_hi ? {24'h0, rx_q[15:8]} :
		hit_lo ? {24'h0, rx_q[7:0]} :
		hit_c1 ? {24'h0, ctrl1_q} :
		hit_c2 ? {24'h0, ctrl2_q} :
		hit_wd ? {16'h0, rx_q} : 32'h0;

	// Mode fault: select pulled low while mastering with detect on
	// Mode fault detection
	wire mode_fault_flag_set  = en && mstr && mode_fault_detect_enable && !spi_ss_n_i;
	// Clear on control one write after armed read
	wire mode_fault_flag_clr  = wr && hit_c1 && mode_fault_flag_arm_q;

	// Receive side
	// Only low byte or word reads count, never high byte
	wire rx_clr    = rd && (hit_lo || hit_wd) && rx_arm_q;
	wire [4:0] nbits = wide ? ssb_pkg::BITS_16 : ssb_pkg::BITS_8;
	wire tick;
	wire shifting  = (state_q == ssb_pkg::ST_SHIFT);
	wire last      = tick && phase_q && (cnt_q == nbits - 5'h1);
	wire [15:0] got = wide ? {sh_q[14:0], rxbit_q} :
		{8'h00, sh_q[6:0], rxbit_q};
	// Move into data register when flag free or being cleared
	wire load_rx   = (last || pend_vld_q) && (!rxf_q || rx_clr);
	wire [15:0] rx_src = last ? got : pend_q;

	// Transmit side
	// Writes only land while transmit register empty
	wire wr_hi     = wr && hit_hi && txe_q;
	wire wr_lo     = wr && hit_lo && txe_q;
	wire wr_wd     = wr && hit_wd && txe_q && (wb_sel_i[1:0] == 2'b11);
	// High byte writes never reach the commit term
	wire tx_commit = tx_arm_q && (wr_lo || wr_wd);
	// Any rate or format change aborts, as does leaving master mode
	wire abort     = mode_fault_flag_set || (wr && (hit_bd || hit_c2)) || !en || !mstr;
	wire start     = (state_q == ssb_pkg::ST_IDLE) && !txe_q && en && mstr &&
		!abort;

	ssb_baud_div u_div (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.pre      (baud_q[ssb_pkg::PRE_LSB +: ssb_pkg::FLD_W]),
		.sel      (baud_q[ssb_pkg::SEL_LSB +: ssb_pkg::FLD_W]),
		.run      (shifting),
		.tick     (tick)
	);

	// Wishbone answer one cycle after the request
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
		end
	end

	// Read data held until the next read
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dat_q <= 32'h0;
		end else if (rd) begin
			dat_q <= rdata;
		end
	end

	// Status has no write path; other registers take writes
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl1_q <= ssb_pkg::CTRL1_RST;
		end else begin
			if (wr && hit_c1)
				ctrl1_q <= wb_dat_i[7:0];
			// Mode fault drops master, winning over a write
			if (mode_fault_flag_set)
				ctrl1_q[ssb_pkg::C1_MSTR_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl2_q <= ssb_pkg::CTRL2_RST;
		end else if (wr && hit_c2) begin
			ctrl2_q <= wb_dat_i[7:0];
		end
	end

	// Reserved baud bits are never stored, so they read zero
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			baud_q <= ssb_pkg::BAUD_RST;
		end else if (wr && hit_bd) begin
			baud_q <= wb_dat_i[7:0] & 8'h77;
		end
	end

	// Receive full flag and its arming
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxf_q    <= ssb_pkg::STATUS_RST[ssb_pkg::RXF_BIT];
			rx_arm_q <= 1'b0;
		end else begin
			// Set terms are ORed after the clear
			// Armed low or word read clears
			rxf_q    <= load_rx || (rxf_q && !rx_clr);
			rx_arm_q <= (rd && hit_st && rxf_q) ||
				(rx_arm_q && !rx_clr && rxf_q);
		end
	end

	// Transmit empty flag and its arming
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			txe_q    <= ssb_pkg::STATUS_RST[ssb_pkg::TXE_BIT];
			tx_arm_q <= 1'b0;
		end else begin
			txe_q    <= start || (txe_q && !tx_commit);
			tx_arm_q <= (rd && hit_st && txe_q) ||
				(tx_arm_q && !tx_commit && txe_q);
		end
	end

	// Mode fault flag; a new fault outranks the clearing write
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_fault_flag_q     <= ssb_pkg::STATUS_RST[ssb_pkg::MODE_FAULT_FLAG_BIT];
			mode_fault_flag_arm_q <= 1'b0;
		end else begin
			mode_fault_flag_q     <= mode_fault_flag_set || (mode_fault_flag_q && !mode_fault_flag_clr);
			mode_fault_flag_arm_q <= (rd && hit_st && mode_fault_flag_q) ||
				(mode_fault_flag_arm_q && !mode_fault_flag_clr && mode_fault_flag_q);
		end
	end

	// Transmit data holding
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_q <= 16'h0;
		end else begin
			if (wr_hi || wr_wd)
				tx_q[15:8] <= wr_wd ? wb_dat_i[15:8] : wb_dat_i[7:0];
			if (wr_lo || wr_wd)
				tx_q[7:0] <= wb_dat_i[7:0];
		end
	end

	// Receive data and the waiting second word
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_q       <= 16'h0;
			pend_q     <= 16'h0;
			pend_vld_q <= 1'b0;
		end else begin
			// A second word waits; unread high data is lost
			if (load_rx)
				rx_q <= rx_src;
			if (last)
				pend_q <= got;
			// A new frame invalidates a word still waiting
			pend_vld_q <= last ? !load_rx :
				(pend_vld_q && !load_rx && !start);
		end
	end

	// Shift engine, mode 0, MSB first from bit 15
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ssb_pkg::ST_IDLE;
			sh_q    <= 16'h0;
			rxbit_q <= 1'b0;
			phase_q <= 1'b0;
			sck_q   <= 1'b0;
			cnt_q   <= 5'h0;
		end else begin
			case (state_q)
				ssb_pkg::ST_IDLE: begin
					sck_q   <= 1'b0;
					phase_q <= 1'b0;
					cnt_q   <= 5'h0;
					if (start) begin
						state_q <= ssb_pkg::ST_SHIFT;
						// Byte mode sends only the low byte
						sh_q <= wide ? tx_q : {tx_q[7:0], 8'h00};
					end
				end
				ssb_pkg::ST_SHIFT: begin
					if (abort) begin
						state_q <= ssb_pkg::ST_IDLE;
						sck_q   <= 1'b0;
					end else if (tick) begin
						phase_q <= !phase_q;
						sck_q   <= !phase_q;
						if (!phase_q) begin
							rxbit_q <= spi_miso_i;
						end else begin
							sh_q  <= {sh_q[14:0], rxbit_q};
							cnt_q <= cnt_q + 5'h1;
							if (last)
								state_q <= ssb_pkg::ST_IDLE;
						end
					end
				end
				default: state_q <= ssb_pkg::ST_IDLE;
			endcase
		end
	end

	assign wb_ack_o   = ack_q;
	assign wb_dat_o   = dat_q;
	assign spi_sck_o  = sck_q;
	assign spi_mosi_o = sh_q[15];
	// Level request while enabled and flag set
	assign spi_irq_o  = ie && (mode_fault_flag_q || rxf_q);
endmodule

/* File: rtl/ssb_pkg.sv */
// Constants shared by the serial status and baud block
package ssb_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_BAUD   = 8'hea;
	localparam logic [7:0] IDX_STATUS = 8'heb;
	localparam logic [7:0] IDX_DHIGH  = 8'hec;
	localparam logic [7:0] IDX_DLOW   = 8'hed;
	localparam logic [7:0] IDX_CTRL1  = 8'hf0;
	localparam logic [7:0] IDX_CTRL2  = 8'hf1;
	localparam logic [7:0] IDX_DWORD  = 8'hf2;

	// Status field positions
	localparam int RXF_BIT  = 7;
	localparam int TXE_BIT  = 5;
	localparam int MODE_FAULT_FLAG_BIT = 4;

	// Control register one field positions
	localparam int C1_EN_BIT   = 0;
	localparam int C1_MSTR_BIT = 1;
	localparam int C1_IE_BIT   = 2;

	// Control register two field positions
	localparam int C2_WIDTH_BIT  = 6;
	localparam int C2_MODE_FAULT_DETECT_ENABLE_BIT = 4;

	// Baud register fields
	localparam int PRE_LSB = 4;
	localparam int SEL_LSB = 0;
	localparam int FLD_W   = 3;

	// Reset values
	localparam logic [7:0] STATUS_RST = 8'h20;
	localparam logic [7:0] CTRL1_RST  = 8'h00;
	localparam logic [7:0] CTRL2_RST  = 8'h00;
	localparam logic [7:0] BAUD_RST   = 8'h00;

	// Timing: bus clock rate and the largest divisor
	localparam int CLK_HZ  = 25000000;
	localparam int DIV_MAX = 2048;
	localparam int HALF_W  = $clog2(DIV_MAX / 2) + 1;

	// Word sizes selected by transfer_width_select
	localparam logic [4:0] BITS_8  = 5'h08;
	localparam logic [4:0] BITS_16 = 5'h10;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b01,
		ST_SHIFT = 2'b10
	} ssb_state_t;
endpackage

/* File: rtl/ssb_baud_div.sv */
// Baud divider: one tick per half serial bit period
`timescale 1ns/1ps
module ssb_baud_div (
	input  wire logic                       core_clk, // Bus clock
	input  wire logic                       rst_n,    // Async reset
	input  wire logic [ssb_pkg::FLD_W-1:0]  pre,      // baud_preselect
	input  wire logic [ssb_pkg::FLD_W-1:0]  sel,      // baud_select
	input  wire logic                       run,      // Count enable
	output logic                            tick      // Half period pulse
);
	logic [ssb_pkg::HALF_W-1:0] half;
	logic [ssb_pkg::HALF_W-1:0] cnt_q;
	logic [ssb_pkg::HALF_W-1:0] cnt_d;
	logic                       wrap;

	// Both at 7: half count 1024, fits HALF_W
	assign half = ssb_pkg::HALF_W'({1'b0, pre} + 4'h1) << sel;
	assign wrap = (cnt_q == half - ssb_pkg::HALF_W'(1));
	// Rate is bus clock over divisor
	assign cnt_d = (!run || wrap) ? '0 : cnt_q + ssb_pkg::HALF_W'(1);
	assign tick = run && wrap;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule

/* File: test/ssb_spi_status_sva.sv */
// Port checker for the SPI status and baud block
`timescale 1ns/1ps
module ssb_spi_status_sva #(
	parameter int ADR_W = 10 // Byte address width
) (
	input wire logic             core_clk,  // Bus clock
	input wire logic             rst_n,     // Async reset
	input wire logic             wb_cyc_i,  // Cycle
	input wire logic             wb_stb_i,  // Strobe
	input wire logic             wb_we_i,   // Write
	input wire logic [ADR_W-1:0] wb_adr_i,  // Byte address
	input wire logic [3:0]       wb_sel_i,  // Byte enables
	input wire logic [31:0]      wb_dat_i,  // Write data
	input wire logic [31:0]      wb_dat_o,  // Read data
	input wire logic             wb_ack_o,  // Acknowledge
	input wire logic             spi_sck_o, // Serial clock
	input wire logic             spi_irq_o  // Interrupt
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire [7:0] idx = wb_adr_i[9:2];
	wire       take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire       c1_wr = take && wb_we_i && wb_sel_i[0]
		&& idx == ssb_pkg::IDX_CTRL1;
	logic ie_q;
	logic run_q;
	// Shadow updated at the taking edge, as the block does
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ie_q  <= 1'h0;
			run_q <= 1'h0;
		end else if (c1_wr) begin
			ie_q  <= wb_dat_i[ssb_pkg::C1_IE_BIT];
			run_q <= &wb_dat_i[1:0];
		end
	end
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_stat_rd;
		wb_ack_o && !wb_we_i && idx == ssb_pkg::IDX_STATUS;
	endsequence
	chk_ack_answer: assert property (s_req |=> wb_ack_o)
		else $error("ack missing after request");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_cause: assert property (wb_ack_o |-> $past(take))
		else $error("ack without request");
	chk_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
		else $error("upper read bits not zero");
	chk_status_zero: assert property (
		s_stat_rd |-> (wb_dat_o[7:0] & 8'h4f) == 8'h0)
		else $error("reserved status bits set");
	chk_irq_gate: assert property (!ie_q |-> !spi_irq_o)
		else $error("irq while disabled");
	chk_irq_mode_fault_flag: assert property (
		s_stat_rd ##0 (ie_q && wb_dat_o[4]) |-> spi_irq_o)
		else $error("irq missing on mode fault");
	chk_sck_idle: assert property (
		!run_q && !$past(run_q) |-> !spi_sck_o)
		else $error("sck active while stopped");
endmodule

/* File: test/ssb_spi_slave.sv */
// Behavioural SPI slave, mode 0, 16-bit shift register
`timescale 1ns/1ps
module ssb_spi_slave #(
	parameter logic [15:0] INIT = 16'hc3a5 // Preloaded reply
) (
	input  wire logic   sck,  // Serial clock
	input  wire logic   mosi, // From master
	output logic        miso, // To master
	output logic [15:0] sh_q  // Shift register
);
	logic        bit_q = 1'h0;
	logic [15:0] reg_q = INIT;
	// Sample on rise, shift on fall so miso is stable at master sampling
	always @(posedge sck) bit_q <= mosi;
	always @(negedge sck) reg_q <= {reg_q[14:0], bit_q};
	assign miso = reg_q[15];
	assign sh_q = reg_q;
endmodule

/* File: test/ssb_spi_status_tb.sv */
// Testbench for the SPI status and baud block
`timescale 1ns/1ps
module ssb_spi_status_tb;
	localparam logic [7:0] ST = ssb_pkg::IDX_STATUS;
	localparam logic [7:0] DL = ssb_pkg::IDX_DLOW;
	localparam logic [7:0] DH = ssb_pkg::IDX_DHIGH;
	localparam logic [7:0] DW = ssb_pkg::IDX_DWORD;
	localparam logic [7:0] C1 = ssb_pkg::IDX_CTRL1;
	localparam logic [7:0] C2 = ssb_pkg::IDX_CTRL2;
	localparam logic [7:0] BR = ssb_pkg::IDX_BAUD;
	logic        core_clk = 1'h0;
	logic        rst_n = 1'h0;
	logic        cyc = 1'h0;
	logic        stb = 1'h0;
	logic        we = 1'h0;
	logic        ss_n = 1'h1;
	logic [9:0]  adr = 10'h0;
	logic [31:0] dat = 32'h0;
	logic [3:0]  sel = 4'hf;
	logic [31:0] rdat;
	logic [31:0] q;
	logic        ack, sck, mosi, miso, irq;
	logic [15:0] sh;
	logic [15:0] psh = 16'hc3a5;
	int          num_errors = 0;
	int          checks = 0;
	int          cycles = 0;
	int          n;
	always #20 core_clk = ~core_clk;
	ssb_spi_status i_ssb_spi_status (.core_clk, .rst_n, .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .spi_sck_o(sck),
		.spi_mosi_o(mosi), .spi_miso_i(miso), .spi_ss_n_i(ss_n),
		.spi_irq_o(irq));
	ssb_spi_slave #(.INIT(16'hc3a5)) i_ssb_spi_slave (.sck, .mosi, .miso,
		.sh_q(sh));
	task automatic report_and_stop();
		if (num_errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			$display("BAD %s exp %h got %h", nm, e, g);
			num_errors++;
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] i,
		input logic [31:0] d);
		@(posedge core_clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= {i, 2'h0};
		dat <= d;
		do @(posedge core_clk); while (ack !== 1'h1);
		q = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] i, input logic [31:0] e,
		input string nm);
		bus(1'h0, i, 32'h0);
		cmp(nm, e, q);
	endtask
	// Polling also arms the receive clear, as software would
	task automatic wait_rx();
		q = 32'h0;
		while (q[7] !== 1'h1) bus(1'h0, ST, 32'h0);
	endtask
	task automatic xfer8(input logic [7:0] b, input logic [7:0] d);
		bus(1'h1, BR, {24'h0, b});
		rd(ST, 32'h20, "txe_armed");
		bus(1'h1, DL, {24'h0, d});
		@(posedge sck);
		n = 0;
		while (sck === 1'h1) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		cmp("half_period", (32'(b[6:4]) + 32'h1) << b[2:0], n);
		wait_rx();
		rd(DH, 32'h0, "high_8bit");
		rd(DH, 32'h0, "high_8bit");
		rd(ST, 32'ha0, "rxf_kept");
		rd(DL, {24'h0, psh[15:8]}, "rx_low");
		rd(ST, 32'h20, "rxf_clear");
		psh = {psh[7:0], d};
		cmp("slave_rx", {24'h0, d}, {24'h0, sh[7:0]});
	endtask
	initial begin
		repeat (3) @(posedge core_clk);
		rst_n <= 1'h1;
		rd(ST, 32'h20, "status_reset");
		bus(1'h1, ST, 32'hff);
		rd(ST, 32'h20, "status_wr");
		rd(BR, 32'h0, "baud_reset");
		rd(8'h00, 32'h0, "unmapped");
		// Writes without the low byte enable are refused
		sel <= 4'he;
		bus(1'h1, BR, 32'h55);
		sel <= 4'hf;
		rd(BR, 32'h0, "baud_no_sel");
		bus(1'h1, C1, 32'h3);
		xfer8(8'h77, 8'ha5);
		xfer8(8'h21, 8'h3c);
		xfer8(8'h00, 8'h96);
		bus(1'h1, C1, 32'h2);
		rd(ST, 32'h20, "txe_idle");
		bus(1'h1, DL, 32'h5a);
		rd(ST, 32'h0, "txe_full");
		bus(1'h1, DL, 32'h11);
		bus(1'h1, C1, 32'h3);
		wait_rx();
		rd(DL, {24'h0, psh[15:8]}, "rx_low");
		cmp("slave_rx", 32'h5a, {24'h0, sh[7:0]});
		psh = {psh[7:0], 8'h5a};
		bus(1'h1, C2, 32'h40);
		rd(ST, 32'h20, "txe16");
		bus(1'h1, DW, 32'h1234);
		wait_rx();
		rd(DL, {24'h0, psh[7:0]}, "rx_low16");
		rd(ST, 32'h20, "rxf_clear16");
		cmp("slave_rx16", 32'h1234, {16'h0, sh});
		bus(1'h1, DH, 32'hab);
		bus(1'h1, DH, 32'hcd);
		rd(ST, 32'h20, "txe_after_high");
		bus(1'h1, DL, 32'hef);
		wait_rx();
		rd(DW, 32'h1234, "rx_word");
		rd(ST, 32'h20, "rxf_clear_word");
		cmp("slave_rx_hl", 32'hcdef, {16'h0, sh});
		// Low byte alone starts a frame; its high byte is not checked
		rd(ST, 32'h20, "txe_low16");
		bus(1'h1, DL, 32'h77);
		wait_rx();
		rd(DL, 32'hef, "rx_low_only");
		cmp("slave_lo16", 32'h77, {24'h0, sh[7:0]});
		bus(1'h1, C1, 32'h7);
		bus(1'h1, C2, 32'h10);
		@(posedge core_clk);
		ss_n <= 1'h0;
		repeat (3) @(posedge core_clk);
		ss_n <= 1'h1;
		rd(ST, 32'h30, "mode_fault_flag_set");
		cmp("irq_mode_fault_flag", 32'h1, {31'h0, irq});
		bus(1'h1, C1, 32'h7);
		rd(ST, 32'h20, "mode_fault_flag_clear");
		cmp("irq_clear", 32'h0, {31'h0, irq});
		report_and_stop();
	end
	// Slowest frame is about 16k cycles; the ceiling leaves ample margin
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 60000) begin
			num_errors++;
			report_and_stop();
		end
	end
endmodule
bind ssb_spi_status ssb_spi_status_sva #(.ADR_W(ADR_W))
	i_ssb_spi_status_sva (.core_clk, .rst_n, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
	.spi_sck_o, .spi_irq_o);
